// file: core/dssp_fifo.sv
// synchronous fifo with valid/ready on both sides
// single clock, width and depth parameters, depth a power of two
`timescale 1ns/1ps
module dssp_fifo #(
  parameter int W     = 32,
  parameter int DEPTH = 8
) (
  input  wire logic         core_clk_in,
  input  wire logic         nrst_in,
  input  wire logic [W-1:0] wr_data_in,
  input  wire logic         wr_valid_in,
  output logic              wr_ready_out,
  output logic [W-1:0]      rd_data_out,
  output logic              rd_valid_out,
  input  wire logic         rd_ready_in,
  output logic [$clog2(DEPTH):0] level_out
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_q [DEPTH];
  logic [AW:0]  wp_q;
  logic [AW:0]  rp_q;
  logic         push;
  logic         pop;

  assign level_out    = wp_q - rp_q;
  assign wr_ready_out = (level_out != (AW+1)'(DEPTH));
  assign rd_valid_out = (wp_q != rp_q);
  assign rd_data_out  = mem_q[rp_q[AW-1:0]];
  assign push         = wr_valid_in & wr_ready_out;
  assign pop          = rd_valid_out & rd_ready_in;

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wp_q <= '0;
    end else if (push) begin
      wp_q <= wp_q + 1'b1;
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rp_q <= '0;
    end else if (pop) begin
      rp_q <= rp_q + 1'b1;
    end
  end

  // storage holds no reset, contents are only read behind valid
  always_ff @(posedge core_clk_in) begin
    if (push) begin
      mem_q[wp_q[AW-1:0]] <= wr_data_in;
    end
  end
endmodule : dssp_fifo

// file: core/dssp_map.svh
// constants for the processor serial port: slot layout, divider and bit positions
// assumes core_clk_in stands for the crystal input, divided by three for the bit clock
`ifndef DSSP_MAP_SVH
`define DSSP_MAP_SVH
// ==========================================================
// framing
`define DSSP_CLK_DIV        2'd3
`define DSSP_SLOT_BITS      5'd16
`define DSSP_SLOTS          4'd12
`define DSSP_FRAME_BITS     8'd192
`define DSSP_PAD_RESET      8'h00
// ==========================================================
// control word fields
`define DSSP_CW_CLR         15
`define DSSP_CW_VI_LO       8
`define DSSP_CW_ALIVE       7
`define DSSP_CW_RW          6
`define DSSP_CW_IDX_HI      5
// ==========================================================
// status word fields, stream count and buffer depth
`define DSSP_SW_PDN         15
`define DSSP_SW_PNPR        14
`define DSSP_SW_VO_LO       8
`define DSSP_SW_RQ_LO       0
`define DSSP_STREAMS        5
`define DSSP_BUF_WORDS      4
`endif

// file: core/dssp_pkg.sv
// types shared by the processor serial port and its test bench
// no assumptions beyond the map header
package dssp_pkg;
  typedef struct packed {
    logic [15:0] right;
    logic [15:0] left;
  } dssp_pair_t;
  typedef struct packed {
    logic       rd;
    logic [5:0] index;
    logic [7:0] data;
    logic       alive;
  } dssp_access_t;
endpackage : dssp_pkg

// file: core/dssp_port.sv
// processor serial port: master framing, slot shifting, intercept path
// core_clk_in is the crystal; codec samples arrive as pairs, substitute pairs leave with valid/ready
`timescale 1ns/1ps
`include "dssp_map.svh"
module dssp_port #(
  parameter int NS = `DSSP_STREAMS
) (
  input  wire logic                 core_clk_in,
  input  wire logic                 nrst_in,
  // link
  input  wire logic                 serial_in_line_in,
  output logic                      serial_out_line_out,
  output logic                      frame_sync_line_out,
  output logic                      bit_clock_out,
  // configuration
  input  wire logic [NS-1:0]        intercept_en_in,
  input  wire logic [7:0]           frame_pad_in,
  input  wire logic [1:0]           status_flags_in,
  // streams as observed, one pair each
  input  wire dssp_pkg::dssp_pair_t mon_pair_in [NS],
  // substitute samples toward the converters, stream 0 only is buffered
  output dssp_pkg::dssp_pair_t      sub_pair_out,
  output logic                      sub_valid_out,
  input  wire logic                 sub_ready_in,
  output logic [NS-1:0]             sub_flag_out,
  // indirect access from the control word, one per frame
  output dssp_pkg::dssp_access_t    access_out,
  output logic                      access_stb_out,
  input  wire logic [15:0]          access_rdata_in
);
  typedef enum logic [1:0] {ST_ACTIVE, ST_PAD} dssp_state_t;

  // ==========================================================
  // bit clock divider
  logic [1:0] div_q;
  logic       rise_en;
  logic       fall_en;
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      div_q <= 2'd0;
    end else begin
      div_q <= (div_q == `DSSP_CLK_DIV - 2'd1) ? 2'd0 : div_q + 2'd1;
    end
  end
  assign rise_en = (div_q == 2'd0);
  assign fall_en = (div_q == 2'd1);
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      bit_clock_out <= 1'b0;
    end else if (rise_en) begin
      bit_clock_out <= 1'b1;
    end else if (fall_en) begin
      bit_clock_out <= 1'b0;
    end
  end

  // ==========================================================
  // frame counters
  dssp_state_t state_q;
  logic [7:0]  bit_q;
  logic [7:0]  pad_q;
  logic [3:0]  slot;
  logic [3:0]  bpos;
  logic        last_act;
  assign slot     = bit_q[7:4];
  assign bpos     = bit_q[3:0];
  assign last_act = (bit_q == `DSSP_FRAME_BITS - 8'd1);
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_q <= ST_ACTIVE;
      bit_q   <= 8'h00;
      pad_q   <= `DSSP_PAD_RESET;
    end else if (rise_en) begin
      case (state_q)
        ST_ACTIVE: begin
          bit_q <= bit_q + 8'd1;
          if (last_act) begin
            bit_q <= 8'h00;
            pad_q <= frame_pad_in;
            if (frame_pad_in != 8'h00) begin
              state_q <= ST_PAD;
            end
          end
        end
        ST_PAD: begin
          pad_q <= pad_q - 8'd1;
          if (pad_q == 8'd1) begin
            state_q <= ST_ACTIVE;
          end
        end
        default: state_q <= ST_ACTIVE;
      endcase
    end
  end
  logic sync_next;
  assign sync_next = (state_q == ST_ACTIVE) ? last_act && frame_pad_in == 8'h00
                                            : pad_q == 8'd1;
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      frame_sync_line_out <= 1'b1;
    end else if (rise_en) begin
      frame_sync_line_out <= sync_next;
    end
  end

  // ==========================================================
  // outbound words
  function automatic logic [15:0] pick(input int s, input dssp_pkg::dssp_pair_t p);
    pick = s[0] ? p.left : p.right;
  endfunction : pick
  logic [NS-1:0] req;
  logic [NS-1:0] req_prev_q;
  logic [NS-1:0] req_shown_q;
  logic [NS-1:0] vo_q;
  logic [3:0]    level;
  logic [15:0]   status_word;
  logic [15:0]   tx_word;
  genvar g;
  generate
    for (g = 1; g < NS; g++) begin : g_req
      assign req[g] = intercept_en_in[g];
    end
  endgenerate
  assign req[0] = intercept_en_in[0] && (level < 4'(`DSSP_BUF_WORDS));
  always_comb begin
    status_word = 16'h0000;
    status_word[`DSSP_SW_PDN:`DSSP_SW_PNPR] = status_flags_in;
    status_word[`DSSP_SW_VO_LO +: NS] = vo_q;
    status_word[`DSSP_SW_RQ_LO +: NS] = req;
  end
  always_comb begin
    tx_word = status_word;
    if (slot == 4'd1) begin
      tx_word = access_rdata_in;
    end else if (slot >= 4'd2) begin
      tx_word = pick(int'(slot), mon_pair_in[(11 - int'(slot)) / 2]);
    end
  end
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      vo_q <= '0;
    end else if (rise_en && bit_q == 8'h00 && state_q == ST_ACTIVE) begin
      vo_q <= {NS{1'b1}};
    end
  end
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      serial_out_line_out <= 1'b0;
    end else if (rise_en) begin
      serial_out_line_out <= (state_q == ST_ACTIVE) ? tx_word[4'd15 - bpos] : 1'b0;
    end
  end

  // ==========================================================
  // inbound shifting on the falling edge
  logic [15:0] rx_q;
  logic [15:0] ctl_q;
  logic [15:0] sub_r_q;
  logic [7:0]  rx_bit_q;
  logic        rx_act_q;
  logic [3:0]  rx_slot;
  logic        word_done;
  // the bit counter has moved on by the falling edge, so keep the
  // index of the bit the far side launched on the rising edge
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rx_bit_q <= 8'h00;
      rx_act_q <= 1'b0;
    end else if (rise_en) begin
      rx_bit_q <= bit_q;
      rx_act_q <= (state_q == ST_ACTIVE);
    end
  end
  assign rx_slot   = rx_bit_q[7:4];
  assign word_done = fall_en && rx_act_q && rx_bit_q[3:0] == 4'd15;
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rx_q <= 16'h0000;
    end else if (fall_en && rx_act_q) begin
      rx_q <= {rx_q[14:0], serial_in_line_in};
    end
  end
  logic [15:0] rx_word;
  assign rx_word = {rx_q[14:0], serial_in_line_in};
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ctl_q      <= 16'h0000;
      access_stb_out <= 1'b0;
      access_out <= '0;
    end else begin
      access_stb_out <= 1'b0;
      if (word_done && rx_slot == 4'd0) begin
        ctl_q <= rx_word;
      end
      if (word_done && rx_slot == 4'd1) begin
        access_stb_out   <= 1'b1;
        access_out.rd    <= ctl_q[`DSSP_CW_RW];
        access_out.index <= ctl_q[`DSSP_CW_IDX_HI:0];
        access_out.data  <= rx_word[7:0];
        access_out.alive <= ctl_q[`DSSP_CW_ALIVE];
      end
    end
  end
  // requests shown in this frame's status, and in the frame before it;
  // substitutions are only taken against the earlier one
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      req_shown_q <= '0;
      req_prev_q  <= '0;
    end else if (rise_en && bit_q == 8'h00 && state_q == ST_ACTIVE) begin
      req_shown_q <= req;
      req_prev_q  <= req_shown_q;
    end
  end

  // ==========================================================
  // substitution for the last stream pair, slots 10 and 11
  logic fifo_ready;
  logic push;
  logic [$clog2(8):0] lvl;
  assign level = 4'(lvl);
  assign push  = word_done && rx_slot == 4'd11 && intercept_en_in[0] && req_prev_q[0]
                 && ctl_q[`DSSP_CW_VI_LO];
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sub_r_q <= 16'h0000;
    end else if (word_done && rx_slot == 4'd10) begin
      sub_r_q <= rx_word;
    end
  end
  dssp_fifo #(.W(32), .DEPTH(8)) u_fifo (
    .core_clk_in (core_clk_in),
    .nrst_in     (nrst_in),
    .wr_data_in  ({sub_r_q, rx_word}),
    .wr_valid_in (push),
    .wr_ready_out(fifo_ready),
    .rd_data_out (sub_pair_out),
    .rd_valid_out(sub_valid_out),
    .rd_ready_in (sub_ready_in),
    .level_out   (lvl)
  );
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sub_flag_out <= '0;
    end else begin
      sub_flag_out <= intercept_en_in & {NS{fifo_ready}};
    end
  end
endmodule : dssp_port

// file: test/dssp_port_asserts.sv
// pin checker for the processor serial port
// bound to every dssp_port, sees its ports only
`timescale 1ns/1ps
module dssp_port_asserts (
  input  wire logic       core_clk_in,
  input  wire logic       nrst_in,
  input  wire logic       serial_out_line_out,
  input  wire logic       frame_sync_line_out,
  input  wire logic       bit_clock_out,
  input  wire logic [7:0] frame_pad_in,
  input  wire logic       access_stb_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);
  logic        bc;
  logic        fs;
  logic        fs_q;
  logic        seen_q;
  logic [11:0] cyc_q;
  logic [7:0]  pad_q;
  logic [1:0]  stb_q;
  assign bc = bit_clock_out;
  assign fs = frame_sync_line_out;
  // ======
  // frame length and strobe count
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      fs_q <= 1'b1;
      seen_q <= 1'b0;
      cyc_q <= 12'h000;
      pad_q <= 8'h00;
      stb_q <= 2'h0;
    end else begin
      fs_q <= fs;
      cyc_q <= (fs && !fs_q) ? 12'h001 : cyc_q + 12'h001;
      if (fs && !fs_q) begin
        seen_q <= 1'b1;
        pad_q <= frame_pad_in;
        stb_q <= 2'h0;
      end else if (access_stb_out && stb_q != 2'h3) begin
        stb_q <= stb_q + 2'h1;
      end
    end
  end
  // ======
  // assertions
  bclk_div_a: assert property ($rose(bc) |=> !bc ##1 !bc ##1 bc)
    else $error("bit clock not a divide by three");
  bclk_run_a: assert property ($fell(bc) |=> !bc ##1 bc)
    else $error("bit clock stalled");
  data_edge_a: assert property (!$rose(bc) |-> $stable(serial_out_line_out))
    else $error("data changed off rising bit clock");
  sync_edge_a: assert property (!$rose(bc) |-> $stable(fs))
    else $error("sync changed off rising bit clock");
  sync_width_a: assert property ($rose(fs) |-> fs [*3] ##1 !fs)
    else $error("sync not one bit period");
  frame_len_a: assert property ($rose(fs) && seen_q && pad_q == frame_pad_in
    |-> cyc_q == 12'd576 + {4'h0, pad_q} * 12'd3)
    else $error("frame length wrong");
  stb_pulse_a: assert property (access_stb_out |=> !access_stb_out)
    else $error("access strobe longer than a cycle");
  stb_once_a: assert property ($rose(fs) && seen_q |-> stb_q == 2'h1)
    else $error("not one access per frame");
endmodule : dssp_port_asserts

bind dssp_port dssp_port_asserts chk_u (.core_clk_in, .nrst_in, .serial_out_line_out,
  .frame_sync_line_out, .bit_clock_out, .frame_pad_in, .access_stb_out);

// file: test/dssp_port_test.sv
// self-checking bench for dssp_port against the processor model
// drives at falling core clock, one design instance
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module dssp_port_test;
  logic                   core_clk_in = 1'b0;
  logic                   nrst_in = 1'b0;
  logic                   sin, sout, fs, bc, sub_valid, stb;
  logic                   sub_ready = 1'b0;
  logic [4:0]             en = 5'h00;
  logic [4:0]             flag;
  logic [7:0]             pad = 8'h00;
  logic [1:0]             sflags = 2'h0;
  logic [15:0]            rdata = 16'h0000;
  logic [15:0]            r, l;
  dssp_pkg::dssp_pair_t   mon [5];
  dssp_pkg::dssp_pair_t   sub_pair;
  dssp_pkg::dssp_pair_t   exp_q [$];
  dssp_pkg::dssp_access_t acc, acc_q;
  int                     n_errors = 0, checks_done = 0, cyc = 0, got = 0;
  int                     sh = 1, shp = 1, lv = 0;
  int                     seed = 32'h79030a1a;
  dssp_port dut_u (.core_clk_in, .nrst_in, .serial_in_line_in(sin), .serial_out_line_out(sout),
    .frame_sync_line_out(fs), .bit_clock_out(bc), .intercept_en_in(en), .frame_pad_in(pad),
    .status_flags_in(sflags), .mon_pair_in(mon), .sub_pair_out(sub_pair),
    .sub_valid_out(sub_valid), .sub_ready_in(sub_ready), .sub_flag_out(flag),
    .access_out(acc), .access_stb_out(stb), .access_rdata_in(rdata));
  dssp_proc_model proc_u (.bit_clock_in(bc), .frame_sync_in(fs), .data_from_dev_in(sout),
    .data_to_dev_out(sin));
  always #50 core_clk_in = ~core_clk_in;
  // ======
  // result watchers
  always @(posedge core_clk_in) begin
    cyc++;
    if (stb) acc_q <= acc;
    if (sub_valid && sub_ready) begin
      got++;
      if (exp_q.size() == 0) exp_q.push_back('x);
      `CHK(sub_pair, exp_q[0])
      exp_q.pop_front();
    end
    if (cyc == 60000) begin
      n_errors++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out
  task automatic wait_fr(int k);
    int t;
    t = proc_u.frames + k;
    while (proc_u.frames < t) @(negedge core_clk_in);
  endtask : wait_fr
  task automatic load(logic [15:0] ctl, logic [15:0] rr, logic [15:0] ll);
    proc_u.tx_word[0] = ctl;
    proc_u.tx_word[1] = {8'h00, ctl[15:8] ^ 8'h5a};
    for (int s = 2; s < 10; s++) proc_u.tx_word[s] = 16'($random(seed));
    proc_u.tx_word[10] = rr;
    proc_u.tx_word[11] = ll;
  endtask : load
  // ======
  // main sequence
  initial begin
    for (int i = 0; i < 5; i++) mon[i] = '0;
    load(16'h0000, 16'h0000, 16'h0000);
    repeat (3) @(negedge core_clk_in);
    nrst_in = 1'b1;
    // monitor mode, each stream enabled in turn, read and write accesses
    for (int m = 0; m < 7; m++) begin
      for (int i = 0; i < 5; i++) mon[i] = $random(seed);
      rdata = 16'($random(seed));
      sflags = 2'(m);
      pad = 8'(m * 3);
      en = (m == 0) ? 5'h00 : (m == 6) ? 5'h1f : 5'h01 << (m - 1);
      load({8'h00, 1'b1, m[0], 6'(m * 9)}, 16'h0000, 16'h0000);
      wait_fr(3);
      `CHK(proc_u.rx_word[0][15:14], sflags)
      `CHK(proc_u.rx_word[0][4:0], en)
      `CHK(proc_u.rx_word[0][12:8], 5'h1f)
      `CHK(flag, en)
      if (m[0]) `CHK(proc_u.rx_word[1], rdata)
      for (int s = 2; s < 12; s++)
        `CHK(proc_u.rx_word[s], s % 2 ? mon[(11-s)/2].left : mon[(11-s)/2].right)
      `CHK(acc_q, {m[0], 6'(m * 9), 8'h5a, 1'b1})
    end
    // stream 0 intercept with the converter side stalled until full
    en = 5'h01;
    load(16'h00c0, 16'h0000, 16'h0000);
    wait_fr(2);
    for (int k = 0; k < 12; k++) begin
      r = 16'($random(seed));
      l = 16'($random(seed));
      // request seen in the frame before decides, buffer counts as four
      shp = sh;
      sh = (lv < 4);
      if (shp) begin
        exp_q.push_back({r, l});
        lv++;
      end
      load(16'h01c0, r, l);
      wait_fr(1);
    end
    load(16'h00c0, 16'h0000, 16'h0000);
    wait_fr(2);
    `CHK(proc_u.rx_word[0][0], 1'b0)
    repeat (60) begin
      @(negedge core_clk_in);
      sub_ready = 1'($random(seed));
    end
    sub_ready = 1'b1;
    wait_fr(2);
    `CHK(proc_u.rx_word[0][0], 1'b1)
    // valid flag without intercept enabled is ignored
    en = 5'h00;
    load(16'h01c0, 16'h1234, 16'h4321);
    wait_fr(3);
    `CHK(got, lv)
    `CHK(exp_q.size(), 0)
    close_out();
  end
endmodule : dssp_port_test

// file: test/dssp_proc_model.sv
// far-side processor: shifts slot words in, captures slot words out
// bench loads tx_word between frames and reads rx_word after one
`timescale 1ns/1ps
module dssp_proc_model (
  input  wire logic bit_clock_in,
  input  wire logic frame_sync_in,
  input  wire logic data_from_dev_in,
  output logic      data_to_dev_out
);
  logic [15:0] tx_word [12];
  logic [15:0] rx_word [12];
  int          frames = 0;
  int          n = 999;
  logic        fs_q = 1'b0;
  initial data_to_dev_out = 1'b0;
  // ======
  // clock and sync only listened to, never driven
  always @(posedge bit_clock_in) begin
    if (fs_q) n = 0;
    else if (n < 999) n = n + 1;
    // idle line toggles so a stale bit never reads as data
    data_to_dev_out <= (n < 192) ? tx_word[n/16][15-n%16] : ~data_to_dev_out;
  end
  always @(negedge bit_clock_in) begin
    fs_q <= frame_sync_in;
    if (n < 192) rx_word[n/16][15-n%16] <= data_from_dev_in;
    if (n == 191) frames <= frames + 1;
  end
endmodule : dssp_proc_model
